// [rtl/csb_pkg.sv]
// Shared constants and carriers for the cache system-bus master ports.
// Assumes three ports: instruction read, data read, data write, each on
// its own bus clock, all joined to the core clock by word handshakes.
package csb_pkg;

  // Widths of the port address and data paths
  localparam int ADDR_W = 36;
  localparam int DATA_W = 128;
  localparam int LINE_W = 256;

  // Port numbering
  localparam int NUM_PORTS = 3;
  localparam int PORT_IFETCH = 0;
  localparam int PORT_DREAD = 1;
  localparam int PORT_DWRITE = 2;

  // Queue depths: accepted requests, acknowledged pieces, responses
  localparam int PIPE_DEPTH = 3;
  localparam int OUTST_DEPTH = 9;
  localparam int RSP_DEPTH = 2;

  // Transfer sizes in bytes, and the burst limit in lines
  localparam logic [6:0] QW_BYTES = 7'h10;
  localparam logic [6:0] LINE_BYTES = 7'h20;
  localparam logic [4:0] PART_MAX = 5'h0f;
  localparam logic [4:0] BURST_MAX_LINES = 5'h03;

  // Kind of request from a cache controller
  typedef enum logic [1:0] {
    KIND_LINE32,
    KIND_LINE16,
    KIND_PARTIAL,
    KIND_BURST
  } csb_kind_t;

  // Width of the attached bus
  typedef enum logic [1:0] {
    WIDTH_32,
    WIDTH_64,
    WIDTH_128
  } csb_width_t;

  // Request from a cache controller; count is bytes or burst lines
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    csb_kind_t kind;
    logic [4:0] count;
    logic [LINE_W-1:0] wdata;
  } csb_req_t;

  // Response: one quadword of read data, or a write completion
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic last;
  } csb_rsp_t;

  // Address phase of one bus transaction
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rnw;
    logic [6:0] nbytes;
  } csb_bus_req_t;

  // Acknowledged piece waiting for its data beats
  typedef struct packed {
    logic [4:0] pos;
    logic [4:0] beats;
    logic last;
  } csb_piece_t;

endpackage : csb_pkg

// [rtl/csb_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock; outputs of the read side come straight from storage.
`timescale 1ns/1ps
module csb_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  // Full and empty follow the occupancy count exactly
  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage needs no reset; only the pointers and the count carry state
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end

endmodule : csb_fifo

// [rtl/csb_word_cdc.sv]
// Toggle handshake that carries one word between two unrelated clocks.
// Assumes each side has a reset already released in its own domain.
`timescale 1ns/1ps
module csb_word_cdc #(
  parameter int W = 8
) (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [W-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic dst_valid,
  input wire logic dst_ready,
  output logic [W-1:0] dst_data
);
  logic req_tgl;
  logic ack_s1;
  logic ack_s2;
  logic req_d1;
  logic req_d2;
  logic ack_tgl;
  logic [W-1:0] hold;

  // One word in flight; throughput traded for a simple safe crossing
  assign src_ready = (ack_s2 == req_tgl);
  assign dst_valid = (req_d2 != ack_tgl);
  assign dst_data = hold;

  // Source side captures the word, then flips the request
  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      req_tgl <= 1'b0;
      hold <= '0;
    end else if (src_valid && src_ready) begin
      req_tgl <= ~req_tgl;
      hold <= src_data;
    end
  end

  // Acknowledge returns through two flops
  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // Request arrives through two flops; hold is stable while it differs
  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      req_d1 <= 1'b0;
      req_d2 <= 1'b0;
      ack_tgl <= 1'b0;
    end else begin
      req_d1 <= req_tgl;
      req_d2 <= req_d1;
      if (dst_valid && dst_ready) begin
        ack_tgl <= ~ack_tgl;
      end
    end
  end

endmodule : csb_word_cdc

// [rtl/csb_master_ports.sv]
// Three system-bus master ports serving the instruction and data caches.
// Assumes cache controllers on CLK and a bus arbiter on each BUS_CLK bit;
// the slave returns narrow data in the low lanes of the read data bus.
`timescale 1ns/1ps

module csb_master_ports #(
  parameter int PIPE_DEPTH = csb_pkg::PIPE_DEPTH,
  parameter int OUTST_DEPTH = csb_pkg::OUTST_DEPTH,
  parameter int RSP_DEPTH = csb_pkg::RSP_DEPTH
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [csb_pkg::NUM_PORTS-1:0] BUS_CLK,
  input wire logic [csb_pkg::NUM_PORTS-1:0] CORE_REQ_VALID,
  output logic [csb_pkg::NUM_PORTS-1:0] CORE_REQ_READY,
  input wire csb_pkg::csb_req_t [csb_pkg::NUM_PORTS-1:0] CORE_REQ,
  output logic [csb_pkg::NUM_PORTS-1:0] CORE_REQ_ERR,
  output logic [csb_pkg::NUM_PORTS-1:0] CORE_RSP_VALID,
  input wire logic [csb_pkg::NUM_PORTS-1:0] CORE_RSP_READY,
  output csb_pkg::csb_rsp_t [csb_pkg::NUM_PORTS-1:0] CORE_RSP,
  input wire csb_pkg::csb_width_t [csb_pkg::NUM_PORTS-1:0] BUS_WIDTH,
  output logic [csb_pkg::NUM_PORTS-1:0] BUS_REQ_VALID,
  output csb_pkg::csb_bus_req_t [csb_pkg::NUM_PORTS-1:0] BUS_REQ,
  input wire logic [csb_pkg::NUM_PORTS-1:0] BUS_ADDR_ACK,
  input wire logic [csb_pkg::NUM_PORTS-1:0] BUS_DATA_ACK,
  output logic [csb_pkg::NUM_PORTS-1:0] BUS_DATA_WAIT,
  input wire logic [csb_pkg::NUM_PORTS-1:0][csb_pkg::DATA_W-1:0] BUS_RD_DATA,
  output logic [csb_pkg::NUM_PORTS-1:0][csb_pkg::DATA_W-1:0] BUS_WR_DATA
);
  localparam int PW = (PIPE_DEPTH > 1) ? $clog2(PIPE_DEPTH) : 1;
  localparam int QW = $clog2(PIPE_DEPTH + 1);
  localparam int REQ_W = $bits(csb_pkg::csb_req_t);
  localparam int RSP_W = $bits(csb_pkg::csb_rsp_t);
  localparam int PIECE_W = $bits(csb_pkg::csb_piece_t);

  // Pointer step around the request queue
  function automatic logic [PW-1:0] step(input logic [PW-1:0] v);
    return (v == PW'(PIPE_DEPTH - 1)) ? '0 : v + 1'b1;
  endfunction : step

  for (genvar p = 0; p < csb_pkg::NUM_PORTS; p++) begin : g_port
    localparam logic IS_WRITE = (p == csb_pkg::PORT_DWRITE);

    // ---------------- Core clock side ----------------
    csb_pkg::csb_req_t r;
    logic legal;
    logic err;
    logic req_src_ready;
    logic rsp_dst_valid;
    logic rsp_dst_ready;
    logic [RSP_W-1:0] rsp_dst_data;
    logic [RSP_W-1:0] rsp_out;

    assign r = CORE_REQ[p];

    // Each port takes only the traffic it is built for
    always_comb begin
      unique case (r.kind)
        csb_pkg::KIND_LINE32: begin
          legal = 1'b1;
        end
        csb_pkg::KIND_BURST: begin
          legal = (p == csb_pkg::PORT_IFETCH) && (r.count != 5'h00) &&
                  (r.count <= csb_pkg::BURST_MAX_LINES);
        end
        csb_pkg::KIND_LINE16: begin
          legal = (p != csb_pkg::PORT_IFETCH);
        end
        csb_pkg::KIND_PARTIAL: begin
          legal = (p != csb_pkg::PORT_IFETCH) && (r.count != 5'h00) &&
                  (r.count <= csb_pkg::PART_MAX) &&
                  (({3'h0, r.addr[3:0]} + {2'h0, r.count}) <=
                   csb_pkg::QW_BYTES);
        end
      endcase
    end

    // Illegal requests are swallowed and flagged; they never reach the bus
    assign CORE_REQ_READY[p] = !legal || req_src_ready;
    assign CORE_REQ_ERR[p] = err;

    always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
        err <= 1'b0;
      end else begin
        err <= CORE_REQ_VALID[p] && !legal;
      end
    end

    // ---------------- Bus clock side ----------------
    logic [1:0] brst_q;
    logic brst;
    logic [1:0] wid1;
    logic [1:0] wid2;
    logic [2:0] lsh;
    logic [6:0] lw;
    logic [6:0] lmask;
    logic cq_valid;
    logic cq_ready;
    logic [REQ_W-1:0] cq_in;
    csb_pkg::csb_req_t cq [PIPE_DEPTH];
    logic [PW-1:0] wp;
    logic [PW-1:0] ip;
    logic [PW-1:0] rp;
    logic [QW-1:0] cnt;
    logic [QW-1:0] ucnt;
    logic [6:0] ioff;
    csb_pkg::csb_req_t cr;
    logic [csb_pkg::ADDR_W-1:0] base;
    logic [csb_pkg::ADDR_W-1:0] paddr;
    logic [6:0] total;
    logic [6:0] sofs;
    logic [6:0] room;
    logic [6:0] rem;
    logic is_line;
    logic [6:0] plen;
    csb_pkg::csb_piece_t npiece;
    logic bvalid;
    csb_pkg::csb_bus_req_t breq;
    csb_pkg::csb_piece_t bpiece;
    logic took;
    logic ld;
    logic trk_in_valid;
    logic trk_in_ready;
    logic trk_valid;
    logic trk_pop;
    logic [PIECE_W-1:0] trk_out;
    csb_pkg::csb_piece_t hd;
    logic hvalid;
    logic dack;
    logic pdone;
    logic [4:0] hbeat;
    logic [6:0] boff;
    logic [4:0] bpos;
    logic [3:0] bidx [16];
    logic [csb_pkg::DATA_W-1:0] asm_q;
    logic [csb_pkg::DATA_W-1:0] next_asm;
    logic [csb_pkg::LINE_W-1:0] wshift;
    logic qend;
    logic emit;
    logic rsp_v;
    csb_pkg::csb_rsp_t rsp_q;
    logic rsp_src_ready;

    // Reset released in step with this bus clock; each port has its own
    always_ff @(posedge BUS_CLK[p] or posedge RESET) begin
      if (RESET) begin
        brst_q <= 2'b11;
      end else begin
        brst_q <= {brst_q[0], 1'b0};
      end
    end
    assign brst = brst_q[1];

    // Bus width is a pin from outside this domain: two flops first
    always_ff @(posedge BUS_CLK[p] or posedge brst) begin
      if (brst) begin
        wid1 <= 2'h0;
        wid2 <= 2'h0;
      end else begin
        wid1 <= BUS_WIDTH[p];
        wid2 <= wid1;
      end
    end

    // Bytes per beat; an unused width code falls back to full width
    always_comb begin
      unique case (wid2)
        csb_pkg::WIDTH_32: lsh = 3'h2;
        csb_pkg::WIDTH_64: lsh = 3'h3;
        default: lsh = 3'h4;
      endcase
    end
    assign lw = 7'h01 << lsh;
    assign lmask = lw - 7'h01;

    // Requests cross from the core clock one word at a time
    csb_word_cdc #(.W(REQ_W)) u_req_cdc (
      .src_clk(CLK),
      .src_rst(RESET),
      .src_valid(CORE_REQ_VALID[p] && legal),
      .src_ready(req_src_ready),
      .src_data(CORE_REQ[p]),
      .dst_clk(BUS_CLK[p]),
      .dst_rst(brst),
      .dst_valid(cq_valid),
      .dst_ready(cq_ready),
      .dst_data(cq_in)
    );

    // Queue of accepted requests; holds write data until retired
    assign cq_ready = (cnt != QW'(PIPE_DEPTH));

    always_ff @(posedge BUS_CLK[p]) begin
      if (cq_valid && cq_ready) begin
        cq[wp] <= cq_in;
      end
    end

    // Issue side: current request and the next piece to place on the bus
    assign cr = cq[ip];

    always_comb begin
      base = cr.addr;
      total = {2'h0, cr.count};
      is_line = 1'b1;
      unique case (cr.kind)
        csb_pkg::KIND_LINE32: begin
          base = {cr.addr[csb_pkg::ADDR_W-1:5], 5'h00};
          total = csb_pkg::LINE_BYTES;
        end
        csb_pkg::KIND_LINE16: begin
          base = {cr.addr[csb_pkg::ADDR_W-1:4], 4'h0};
          total = csb_pkg::QW_BYTES;
        end
        csb_pkg::KIND_BURST: begin
          base = {cr.addr[csb_pkg::ADDR_W-1:5], 5'h00};
          total = {cr.count[1:0], 5'h00};
        end
        csb_pkg::KIND_PARTIAL: begin
          is_line = 1'b0;
        end
      endcase
      paddr = base + {29'h0, ioff};
      sofs = {3'h0, paddr[3:0]} & ~lmask;
      room = sofs + lw - {3'h0, paddr[3:0]};
      rem = total - ioff;
      plen = is_line ? total : ((rem < room) ? rem : room);
      npiece.pos = is_line ? 5'h00 : sofs[4:0];
      npiece.beats = is_line ? 5'(total >> lsh) : 5'h01;
      npiece.last = is_line || (rem <= room);
    end

    // Address phase is held in flops until the arbiter acknowledges it
    assign BUS_REQ_VALID[p] = bvalid && trk_in_ready;
    assign BUS_REQ[p] = breq;
    assign took = BUS_REQ_VALID[p] && BUS_ADDR_ACK[p];
    assign ld = (ucnt != '0) && (!bvalid || took);

    always_ff @(posedge BUS_CLK[p] or posedge brst) begin
      if (brst) begin
        bvalid <= 1'b0;
        breq <= '0;
        bpiece <= '0;
        ioff <= 7'h00;
      end else begin
        if (ld) begin
          bvalid <= 1'b1;
          breq.addr <= paddr;
          breq.rnw <= !IS_WRITE;
          breq.nbytes <= plen;
          bpiece <= npiece;
          ioff <= npiece.last ? 7'h00 : ioff + plen;
        end else if (took) begin
          bvalid <= 1'b0;
        end
      end
    end

    // Queue pointers and counts: accept, fully issued, retired
    always_ff @(posedge BUS_CLK[p] or posedge brst) begin
      if (brst) begin
        wp <= '0;
        ip <= '0;
        rp <= '0;
        cnt <= '0;
        ucnt <= '0;
      end else begin
        if (cq_valid && cq_ready) begin
          wp <= step(wp);
        end
        if (ld && npiece.last) begin
          ip <= step(ip);
        end
        if (pdone && hd.last) begin
          rp <= step(rp);
        end
        cnt <= cnt + QW'(cq_valid && cq_ready) - QW'(pdone && hd.last);
        ucnt <= ucnt + QW'(cq_valid && cq_ready) - QW'(ld && npiece.last);
      end
    end

    // Acknowledged pieces wait here for their data beats
    csb_fifo #(.W(PIECE_W), .DEPTH(OUTST_DEPTH)) u_track (
      .clk(BUS_CLK[p]),
      .rst(brst),
      .in_valid(trk_in_valid),
      .in_ready(trk_in_ready),
      .in_data(bpiece),
      .out_valid(trk_valid),
      .out_ready(trk_pop),
      .out_data(trk_out)
    );

    // With nothing queued the piece being acknowledged takes data at once
    assign hd = trk_valid ? csb_pkg::csb_piece_t'(trk_out) : bpiece;
    assign hvalid = trk_valid || took;
    assign dack = hvalid && BUS_DATA_ACK[p] && !BUS_DATA_WAIT[p];
    assign pdone = dack && ((hbeat + 5'h01) == hd.beats);
    assign trk_pop = trk_valid && pdone;
    assign trk_in_valid = took && (trk_valid || !pdone);

    // Beat count within the head piece
    always_ff @(posedge BUS_CLK[p] or posedge brst) begin
      if (brst) begin
        hbeat <= 5'h00;
      end else if (pdone) begin
        hbeat <= 5'h00;
      end else if (dack) begin
        hbeat <= hbeat + 5'h01;
      end
    end

    // Byte position of this beat within the line
    assign boff = {2'h0, hbeat} << lsh;
    assign bpos = hd.pos + boff[4:0];
    assign qend = (({3'h0, bpos[3:0]} + lw) == csb_pkg::QW_BYTES);

    // Read steering: narrow beats land at their quadword byte lanes
    for (genvar i = 0; i < 16; i++) begin : g_lane
      assign bidx[i] = 4'(i) - bpos[3:0];
      always_comb begin
        next_asm[8*i +: 8] = asm_q[8*i +: 8];
        if ((4'(i) >= bpos[3:0]) &&
            (7'(i) < ({3'h0, bpos[3:0]} + lw))) begin
          next_asm[8*i +: 8] = BUS_RD_DATA[p][8*bidx[i] +: 8];
        end
      end
    end

    always_ff @(posedge BUS_CLK[p] or posedge brst) begin
      if (brst) begin
        asm_q <= '0;
      end else if (dack) begin
        asm_q <= next_asm;
      end
    end

    // Write steering: oldest request's bytes shifted into the low lanes
    assign wshift = cq[rp].wdata >> {bpos, 3'h0};
    assign BUS_WR_DATA[p] = IS_WRITE ? wshift[csb_pkg::DATA_W-1:0] : '0;

    // Reads answer per quadword; writes answer once the request retires
    assign emit = IS_WRITE ? (pdone && hd.last) :
                  (dack && (qend || (pdone && hd.last)));

    always_ff @(posedge BUS_CLK[p] or posedge brst) begin
      if (brst) begin
        rsp_v <= 1'b0;
        rsp_q <= '0;
      end else if (emit) begin
        rsp_v <= 1'b1;
        rsp_q.data <= IS_WRITE ? '0 : next_asm;
        rsp_q.last <= pdone && hd.last;
      end else if (rsp_src_ready) begin
        rsp_v <= 1'b0;
      end
    end

    // Data is held off while a response still waits for the crossing
    assign BUS_DATA_WAIT[p] = rsp_v || !rsp_src_ready;

    csb_word_cdc #(.W(RSP_W)) u_rsp_cdc (
      .src_clk(BUS_CLK[p]),
      .src_rst(brst),
      .src_valid(rsp_v),
      .src_ready(rsp_src_ready),
      .src_data(rsp_q),
      .dst_clk(CLK),
      .dst_rst(RESET),
      .dst_valid(rsp_dst_valid),
      .dst_ready(rsp_dst_ready),
      .dst_data(rsp_dst_data)
    );

    // Two-entry buffer so a stalled cache controller loses no word
    csb_fifo #(.W(RSP_W), .DEPTH(RSP_DEPTH)) u_rsp_buf (
      .clk(CLK),
      .rst(RESET),
      .in_valid(rsp_dst_valid),
      .in_ready(rsp_dst_ready),
      .in_data(rsp_dst_data),
      .out_valid(CORE_RSP_VALID[p]),
      .out_ready(CORE_RSP_READY[p]),
      .out_data(rsp_out)
    );
    assign CORE_RSP[p] = rsp_out;
  end

endmodule : csb_master_ports

// [tb/csb_ports_checker.sv]
// Concurrent checks on the three ports, bound to the top module.
// Assumes top-level port names and package carriers.
`timescale 1ns/1ps
module csb_ports_checker (
  input logic CLK,
  input logic RESET,
  input logic [2:0] BUS_CLK,
  input logic [2:0] CORE_REQ_VALID,
  input logic [2:0] CORE_REQ_READY,
  input csb_pkg::csb_req_t [2:0] CORE_REQ,
  input logic [2:0] CORE_REQ_ERR,
  input logic [2:0] CORE_RSP_VALID,
  input logic [2:0] CORE_RSP_READY,
  input csb_pkg::csb_rsp_t [2:0] CORE_RSP,
  input csb_pkg::csb_width_t [2:0] BUS_WIDTH,
  input logic [2:0] BUS_REQ_VALID,
  input csb_pkg::csb_bus_req_t [2:0] BUS_REQ,
  input logic [2:0] BUS_ADDR_ACK,
  input logic [2:0][127:0] BUS_WR_DATA
);
  // Line16 and partial codes are the two with odd parity
  AST_FETCH_BAD: assert property (@(posedge CLK) disable iff (RESET)
    CORE_REQ_VALID[0] && ^CORE_REQ[0].kind
    |-> CORE_REQ_READY[0] ##1 CORE_REQ_ERR[0]) else $error("fetch refusal");
  AST_FETCH_OK: assert property (@(posedge CLK) disable iff (RESET)
    CORE_REQ_VALID[0] && CORE_REQ[0].kind == csb_pkg::KIND_LINE32
    |=> !CORE_REQ_ERR[0]) else $error("line fetch flagged");
  AST_RSP_HOLD: assert property (@(posedge CLK) disable iff (RESET)
    CORE_RSP_VALID[1] && !CORE_RSP_READY[1] |=> CORE_RSP_VALID[1]
    && $stable(CORE_RSP[1])) else $error("response not held");
  AST_WR_ZERO: assert property (@(posedge CLK) disable iff (RESET)
    BUS_WR_DATA[0] == 128'h0 && BUS_WR_DATA[1] == 128'h0)
    else $error("write data on read port");
  AST_FETCH_BUS: assert property (@(posedge BUS_CLK[0])
    disable iff (RESET) BUS_REQ_VALID[0] |-> BUS_REQ[0].rnw
    && BUS_REQ[0].addr[4:0] == 5'h00
    && BUS_REQ[0].nbytes inside {7'h20, 7'h40, 7'h60})
    else $error("fetch piece shape");
  AST_WRITE_BUS: assert property (@(posedge BUS_CLK[2])
    disable iff (RESET) BUS_REQ_VALID[2] |-> !BUS_REQ[2].rnw)
    else $error("read on write port");
  AST_QUAD: assert property (@(posedge BUS_CLK[1]) disable iff (RESET)
    BUS_REQ_VALID[1] |-> BUS_REQ[1].nbytes == 7'h20
    || BUS_REQ[1].nbytes != 7'h00
    && 7'(BUS_REQ[1].addr[3:0]) + BUS_REQ[1].nbytes <= 7'h10)
    else $error("piece leaves quadword");
  AST_SLOT: assert property (@(posedge BUS_CLK[1]) disable iff (RESET)
    BUS_REQ_VALID[1] && BUS_WIDTH[1] == csb_pkg::WIDTH_32
    && BUS_REQ[1].nbytes < 7'h10
    |-> 7'(BUS_REQ[1].addr[1:0]) + BUS_REQ[1].nbytes <= 7'h04)
    else $error("narrow piece crosses a word");
  AST_ADDR_HOLD: assert property (@(posedge BUS_CLK[1])
    disable iff (RESET) BUS_REQ_VALID[1] && !BUS_ADDR_ACK[1]
    |=> BUS_REQ_VALID[1] && $stable(BUS_REQ[1]))
    else $error("request dropped before ack");
endmodule : csb_ports_checker

bind csb_master_ports csb_ports_checker u_chk (.CLK, .RESET, .BUS_CLK,
  .CORE_REQ_VALID, .CORE_REQ_READY, .CORE_REQ, .CORE_REQ_ERR,
  .CORE_RSP_VALID, .CORE_RSP_READY, .CORE_RSP, .BUS_WIDTH,
  .BUS_REQ_VALID, .BUS_REQ, .BUS_ADDR_ACK, .BUS_WR_DATA);

// [tb/csb_bus_model.sv]
// Arbiter and slave model for one port: acks, byte pattern, log.
// Assumes narrow beats in low lanes and a free-running bus clock.
`timescale 1ns/1ps
module csb_bus_model (
  input logic clk,
  input logic rst,
  input logic slow,
  input logic hold,
  input csb_pkg::csb_width_t width,
  input logic req_valid,
  input csb_pkg::csb_bus_req_t req,
  output logic addr_ack,
  output logic data_ack,
  input logic data_wait,
  output logic [127:0] rd_data,
  input logic [127:0] wr_data
);
  csb_pkg::csb_bus_req_t q[$], log[$], head, cur;
  logic hv, ph, has;
  logic [35:0] slot;
  logic [127:0] m, bd;
  int beat, nb, w, bad;
  // Byte at an address is its low byte plus a constant
  function automatic logic [127:0] qw(logic [35:0] b);
    for (int i = 0; i < 16; i++) qw[8*i+:8] = b[7:0] + 8'(i) + 8'h3c;
  endfunction : qw
  // Current piece: queued head, or one acked this cycle
  always_comb begin
    w = 4 << width;
    cur = hv ? head : req;
    has = hv || (req_valid && addr_ack);
    slot = (cur.addr & ~36'(w - 1)) + 36'(beat * w);
    nb = (int'(cur.addr[3:0]) % w + int'(cur.nbytes) + w - 1) / w;
    m = '1;
    m = m >> (128 - 8 * w);
    bd = qw(slot) & m;
  end
  // Slow mode pauses every other cycle; lines show junk when idle
  assign addr_ack = req_valid && !(slow && ph);
  assign data_ack = has && !hold && !data_wait && !(slow && ph);
  assign rd_data = has ? bd : ~bd;
  // Log each accepted piece, retire it after its last beat
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      q.delete();
      hv <= 1'b0;
      ph <= 1'b0;
      beat <= 0;
      bad = 0;
    end else begin
      ph <= ~ph;
      if (req_valid && addr_ack) begin
        q.push_back(req);
        log.push_back(req);
      end
      if (data_ack) begin
        if (!cur.rnw && (wr_data & m) !== bd) bad++;
        beat <= (beat + 1 == nb) ? 0 : beat + 1;
        if (beat + 1 == nb) void'(q.pop_front());
      end
      hv <= q.size() != 0;
      head <= (q.size() != 0) ? q[0] : req;
    end
  end
endmodule : csb_bus_model

// [tb/csb_tb.sv]
// Bench: cache requests on three ports, one bus model per port.
// Each bus clock is unrelated in phase to the core clock.
`timescale 1ns/1ps
module testbench;
  logic clk = 0;
  logic rst = 1;
  logic [2:0] bclk = 0;
  logic [2:0] rv = 0, slow = 0, hold = 0;
  logic [2:0] rr = 3'h7;
  csb_pkg::csb_req_t [2:0] rq = '0;
  csb_pkg::csb_width_t [2:0] bw;
  logic [2:0] rdy, err, sv, bv, wt;
  wire [2:0] aack, dack;
  wire [2:0][127:0] rd;
  logic [2:0][127:0] wr;
  csb_pkg::csb_rsp_t [2:0] rsp;
  csb_pkg::csb_bus_req_t [2:0] breq;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;

  csb_master_ports dut (.CLK(clk), .RESET(rst), .BUS_CLK(bclk),
    .CORE_REQ_VALID(rv), .CORE_REQ_READY(rdy), .CORE_REQ(rq),
    .CORE_REQ_ERR(err), .CORE_RSP_VALID(sv), .CORE_RSP_READY(rr),
    .CORE_RSP(rsp), .BUS_WIDTH(bw), .BUS_REQ_VALID(bv), .BUS_REQ(breq),
    .BUS_ADDR_ACK(aack), .BUS_DATA_ACK(dack), .BUS_DATA_WAIT(wt),
    .BUS_RD_DATA(rd), .BUS_WR_DATA(wr));

  // Off-grid phases keep bus edges away from core edges
  for (genvar i = 0; i < 3; i++) begin : g
    initial begin
      #(3.3 + 7 * i);
      forever #24 bclk[i] = ~bclk[i];
    end
    csb_bus_model m (.clk(bclk[i]), .rst(rst), .slow(slow[i]),
      .hold(hold[i]), .width(bw[i]), .req_valid(bv[i]), .req(breq[i]),
      .addr_ack(aack[i]), .data_ack(dack[i]), .data_wait(wt[i]),
      .rd_data(rd[i]), .wr_data(wr[i]));
  end

  always #2.5 clk = ~clk;
  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(string nm, logic [127:0] got, logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Request held until ready is seen at an edge
  task automatic send(int p, csb_pkg::csb_kind_t k, logic [35:0] a,
      logic [4:0] c);
    int t = 0;
    @(posedge clk);
    rq[p] <= '{addr: a, kind: k, count: c, wdata: {g[0].m.qw(36'h410),
      g[0].m.qw(36'h400)}};
    rv[p] <= 1'b1;
    do @(posedge clk); while (rdy[p] !== 1'b1 && ++t < 300);
    check("taken", rdy[p], 1'b1);
    rv[p] <= 1'b0;
  endtask : send

  task automatic recv(int p, logic [127:0] d, logic [127:0] mk, logic l);
    int t = 0;
    do @(posedge clk); while (!(sv[p] === 1'b1 && rr[p]) && ++t < 400);
    check("rsp data", rsp[p].data & mk, d & mk);
    check("rsp last", rsp[p].last, l);
  endtask : recv

  // Refusal first, so a leaked piece shows in the log
  task automatic t_fetch;
    int s;
    s = g[0].m.log.size();
    send(0, csb_pkg::KIND_PARTIAL, 36'h100, 5'h04);
    @(posedge clk);
    check("refused", err[0], 1'b1);
    send(0, csb_pkg::KIND_LINE32, 36'h8_1234_5678, 5'h00);
    for (int q = 0; q < 2; q++)
      recv(0, g[0].m.qw(36'h8_1234_5660 + 36'(16 * q)), '1, q == 1);
    check("fetch addr", g[0].m.log[s].addr, 36'h8_1234_5660);
    check("fetch size", g[0].m.log[s].nbytes, 7'h20);
    send(0, csb_pkg::KIND_BURST, 36'h2040, 5'h03);
    for (int q = 0; q < 6; q++)
      recv(0, g[0].m.qw(36'h2040 + 36'(16 * q)), '1, q == 5);
    check("burst size", g[0].m.log[s+1].nbytes, 7'h60);
  endtask : t_fetch

  // Partial read on a 32-bit bus, then refused requests
  task automatic t_partial;
    int s;
    s = g[1].m.log.size();
    send(1, csb_pkg::KIND_PARTIAL, 36'h101, 5'h0f);
    recv(1, g[0].m.qw(36'h100), {{15{8'hff}}, 8'h00}, 1'b1);
    check("pieces", g[1].m.log.size(), s + 4);
    for (int i = 0; i < 4; i++)
      check("piece", g[1].m.log[s+i].addr, 36'h100 + 36'(4*i + (i == 0)));
    for (int i = 0; i < 3; i++) begin
      send(1, i == 2 ? csb_pkg::KIND_BURST : csb_pkg::KIND_PARTIAL,
        36'h10c, i == 0 ? 5'h08 : 5'h00);
      @(posedge clk);
      check("refused", err[1], 1'b1);
    end
  endtask : t_partial

  // Data held back while requests pile up; receiver stalls
  task automatic t_pipe;
    int s;
    s = g[1].m.log.size();
    slow[1] <= 1'b1;
    hold[1] <= 1'b1;
    rr[1] <= 1'b0;
    for (int i = 0; i < 3; i++)
      send(1, csb_pkg::KIND_LINE16, 36'h205 + 36'(16 * i), 5'h00);
    for (int t = 0; t < 400 && g[1].m.log.size() < s + 3; t++)
      @(posedge clk);
    check("queued", g[1].m.log.size(), s + 3);
    check("line16", g[1].m.log[s].nbytes, 7'h10);
    hold[1] <= 1'b0;
    repeat (200) @(posedge clk);
    rr[1] <= 1'b1;
    for (int i = 0; i < 3; i++)
      recv(1, g[0].m.qw(36'h200 + 36'(16 * i)), '1, 1'b1);
    s = g[1].m.log.size();
    hold[1] <= 1'b1;
    for (int i = 0; i < 3; i++)
      send(1, csb_pkg::KIND_PARTIAL, 36'h302 + 36'(16 * i), 5'h08);
    for (int t = 0; t < 400 && g[1].m.log.size() < s + 9; t++)
      @(posedge clk);
    check("outstanding", g[1].m.log.size(), s + 9);
    hold[1] <= 1'b0;
    for (int i = 0; i < 3; i++)
      recv(1, g[0].m.qw(36'h300 + 36'(16 * i)), {64'h0,
        64'hffff_ffff_ffff_ffff} << 16, 1'b1);
  endtask : t_pipe

  // Line writes on a 64-bit bus; model checks each beat
  task automatic t_write;
    int s;
    for (int i = 0; i < 2; i++) begin
      s = g[2].m.log.size();
      send(2, i == 0 ? csb_pkg::KIND_LINE32 : csb_pkg::KIND_LINE16,
        36'h400, 5'h00);
      recv(2, '0, '1, 1'b1);
      check("write size", g[2].m.log[s].nbytes, i ? 7'h10 : 7'h20);
    end
    check("write beats", g[2].m.bad, 0);
  endtask : t_write

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Reset spans three bus edges so every bus domain sees it
  initial begin
    bw[0] = csb_pkg::WIDTH_128;
    bw[1] = csb_pkg::WIDTH_32;
    bw[2] = csb_pkg::WIDTH_64;
    repeat (32) @(posedge clk);
    rst <= 1'b0;
    repeat (40) @(posedge clk);
    t_fetch();
    t_partial();
    t_pipe();
    t_write();
    stop_test();
  end
endmodule : testbench
